// *** rtl/sram_host_pkg.sv ***
/*
  Shared constants for the static memory host controller: pin widths,
  timing figures in ns and their cycle counts at the core clock rate.
  Assumes a single 200 MHz clock and no software-visible registers.
*/
package sram_host_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 5000;
  // timing figures as printed, in ns
  localparam int T_RC_NS = 45;
  localparam int T_AA_NS = 45;
  localparam int T_WC_NS = 45;
  localparam int T_PWE_NS = 35;
  localparam int T_AW_NS = 35;
  localparam int T_HZOE_NS = 18;
  localparam int STROBE_TO_FLOAT_DELAY_NS = 18;
  localparam int DATA_SETUP_TO_WRITE_END_NS = 25;
  localparam int T_LZWE_NS = 10;
  // least times round up to whole cycles
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  // strobe low time: at least pulse width and float delay plus data setup
  localparam int WR_LOW_NS = (T_PWE_NS > STROBE_TO_FLOAT_DELAY_NS + DATA_SETUP_TO_WRITE_END_NS)
                           ? T_PWE_NS : STROBE_TO_FLOAT_DELAY_NS + DATA_SETUP_TO_WRITE_END_NS;
  localparam int RD_CYC = ns_to_cyc(T_AA_NS) + 2; // two extra for input sync
  localparam int WR_LOW_CYC = ns_to_cyc(WR_LOW_NS);
  localparam int RECOVER_CYC = ns_to_cyc(T_LZWE_NS);
  localparam int CNT_W = 5;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;
endpackage

// *** rtl/sram_pins_if.sv ***
/*
  Interface carrying the memory pin group between the sequencer and the
  pin register stage. Assumes both ends on the same clock.
*/
`timescale 1ns/1ps
interface sram_pins_if;
  logic [sram_host_pkg::ADDR_W-1:0] addr;
  logic                             sel_n;
  logic                             wr_n;
  logic                             oe_n;
  logic [sram_host_pkg::DATA_W-1:0] wdata;
  logic                             drive;
  logic [sram_host_pkg::DATA_W-1:0] rdata;
  modport ctrl (output addr, sel_n, wr_n, oe_n, wdata, drive, input rdata);
  modport pins (input addr, sel_n, wr_n, oe_n, wdata, drive, output rdata);
endinterface

// *** rtl/sram_pin_stage.sv ***
/*
  Pin stage: registers every memory pin output and synchronises the data
  inputs through two flip-flops. Assumes pins go straight to the board.
*/
`timescale 1ns/1ps
module sram_pin_stage (
  input  wire logic                             clk_in,
  input  wire logic                             rst_in,
  sram_pins_if.pins                             p,
  input  wire logic [sram_host_pkg::DATA_W-1:0] data_pin_in,
  output logic      [sram_host_pkg::ADDR_W-1:0] addr_out,
  output logic                                  primary_select_n_out,
  output logic                                  secondary_select_out,
  output logic                                  write_strobe_n_out,
  output logic                                  output_drive_n_out,
  output logic      [sram_host_pkg::DATA_W-1:0] data_pin_out,
  output logic                                  data_pin_oe_n_out
);
  logic [sram_host_pkg::DATA_W-1:0] sync1_q, sync1_d, sync2_q, sync2_d;

  // two-flop capture of the returned data
  always_comb begin
    sync1_d = data_pin_in;
    sync2_d = sync1_q;
  end
  assign p.rdata = sync2_q;

  // registered pin drivers, idle deselected with bus floated
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_out             <= sram_host_pkg::ADDR_RESET;
      primary_select_n_out <= 1'b1;
      secondary_select_out <= 1'b0;
      write_strobe_n_out   <= 1'b1;
      output_drive_n_out   <= 1'b1;
      data_pin_out         <= sram_host_pkg::DATA_RESET;
      data_pin_oe_n_out    <= 1'b1;
      sync1_q              <= sram_host_pkg::DATA_RESET;
      sync2_q              <= sram_host_pkg::DATA_RESET;
    end else begin
      addr_out             <= p.addr;
      primary_select_n_out <= p.sel_n;
      secondary_select_out <= ~p.sel_n;
      write_strobe_n_out   <= p.wr_n;
      output_drive_n_out   <= p.oe_n;
      data_pin_out         <= p.wdata;
      data_pin_oe_n_out    <= ~p.drive;
      sync1_q              <= sync1_d;
      sync2_q              <= sync2_d;
    end
  end
endmodule

// *** rtl/sram_host_ctrl.sv ***
/*
  Host controller for a byte-wide asynchronous static memory: takes one
  read or write request at a time and sequences selects, strobes, address
  and data pins. Assumes the memory is wired straight to the pin outputs.
*/
`timescale 1ns/1ps
module sram_host_ctrl (
  input  wire logic                             clk_in,
  input  wire logic                             rst_in,
  input  wire logic                             req_valid_in,
  input  wire logic                             req_write_in,
  input  wire logic [sram_host_pkg::ADDR_W-1:0] req_addr_in,
  input  wire logic [sram_host_pkg::DATA_W-1:0] req_wdata_in,
  output logic                                  req_ready_out,
  output logic                                  rsp_valid_out,
  output logic      [sram_host_pkg::DATA_W-1:0] rsp_rdata_out,
  input  wire logic [sram_host_pkg::DATA_W-1:0] data_pin_in,
  output logic      [sram_host_pkg::ADDR_W-1:0] addr_out,
  output logic                                  primary_select_n_out,
  output logic                                  secondary_select_out,
  output logic                                  write_strobe_n_out,
  output logic                                  output_drive_n_out,
  output logic      [sram_host_pkg::DATA_W-1:0] data_pin_out,
  output logic                                  data_pin_oe_n_out
);
  typedef enum logic [2:0] {IDLE, RD_SETUP, RD_WAIT, WR_SETUP, WR_LOW,
                            WR_HOLD, RECOVER} state_t;

  // ***********************************************************
  // sequencer state
  // ***********************************************************
  state_t                                state_q, state_d;
  logic [sram_host_pkg::CNT_W-1:0]       cnt_q, cnt_d;
  logic [sram_host_pkg::ADDR_W-1:0]      addr_q, addr_d;
  logic [sram_host_pkg::DATA_W-1:0]      wdata_q, wdata_d;
  logic [sram_host_pkg::DATA_W-1:0]      rdata_q, rdata_d;
  logic                                  ready_q, ready_d;
  logic                                  rsp_q, rsp_d;
  logic                                  sel_n;  // combined select intent, low active
  logic                                  wr_n;   // write strobe intent, low active
  logic                                  oe_n;   // output drive intent, low active
  logic                                  drive;  // host owns the data pins

  sram_pins_if pins_bus ();

  // ***********************************************************
  // wait counter compare
  // ***********************************************************
  // true on the last cycle of a wait that lasts len cycles
  // len is a cycle count from the package, at least one
  function automatic logic count_done(input logic [sram_host_pkg::CNT_W-1:0] cnt,
                                      input int                              len);
    return cnt == sram_host_pkg::CNT_W'(len - 1);
  endfunction

  // ***********************************************************
  // request sequencer
  // ***********************************************************
  // one access in flight: a request is only taken in idle with ready shown
  // read: address out first, then selects and output drive for the wait,
  //   one capture edge, then a deselected recovery gap
  // write: selects out, strobe low for the write time, one hold cycle
  //   with strobe high and data still driven, then the same recovery gap
  // the counter restarts from zero at every phase change
  // pin outputs trail these states by the one register stage
  // next-state and pin intent
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    ready_d = 1'b0;
    rsp_d   = 1'b0;
    sel_n   = 1'b1;
    wr_n    = 1'b1;
    oe_n    = 1'b1;
    drive   = 1'b0;
    // one branch per phase of the access
    case (state_q)
      IDLE: begin
        // ready shown until a request is taken
        ready_d = 1'b1;
        if (req_valid_in && ready_q) begin
          ready_d = 1'b0;
          addr_d  = req_addr_in;
          wdata_d = req_wdata_in;
          cnt_d   = '0;
          state_d = req_write_in ? WR_SETUP : RD_SETUP;
        end
      end
      RD_SETUP: begin
        // address already on pins one cycle before select goes active
        state_d = RD_WAIT;
      end
      RD_WAIT: begin
        // selects and output drive held through the access and sync delay
        sel_n = 1'b0;
        oe_n  = 1'b0;
        cnt_d = cnt_q + 1'b1;
        if (count_done(cnt_q, sram_host_pkg::RD_CYC + 1)) begin
          rdata_d = pins_bus.rdata;
          rsp_d   = 1'b1;
          cnt_d   = '0;
          state_d = RECOVER;
        end
      end
      WR_SETUP: begin
        // selects first, output drive stays off so memory is floating
        sel_n   = 1'b0;
        state_d = WR_LOW;
      end
      WR_LOW: begin
        // strobe low with the byte driven, memory outputs already off
        sel_n = 1'b0;
        wr_n  = 1'b0;
        drive = 1'b1;
        cnt_d = cnt_q + 1'b1;
        if (count_done(cnt_q, sram_host_pkg::WR_LOW_CYC)) begin
          cnt_d   = '0;
          state_d = WR_HOLD;
        end
      end
      WR_HOLD: begin
        // strobe rises here and ends the write; data held this cycle
        sel_n   = 1'b0;
        drive   = 1'b1;
        rsp_d   = 1'b1;
        state_d = RECOVER;
      end
      RECOVER: begin
        // deselected gap so the memory enters standby between accesses
        cnt_d = cnt_q + 1'b1;
        if (count_done(cnt_q, sram_host_pkg::RECOVER_CYC)) begin
          cnt_d   = '0;
          ready_d = 1'b1;
          state_d = IDLE;
        end
      end
      default: begin
        // unused codes fall back to idle
        state_d = IDLE;
      end
    endcase
  end

  // ***********************************************************
  // pin intent to the pin stage
  // ***********************************************************
  // pin intent onto the interface
  // the pin stage registers these once more
  assign pins_bus.addr  = addr_q;
  assign pins_bus.sel_n = sel_n;
  assign pins_bus.wr_n  = wr_n;
  assign pins_bus.oe_n  = oe_n;
  assign pins_bus.wdata = wdata_q;
  assign pins_bus.drive = drive;

  // ***********************************************************
  // state registers
  // ***********************************************************
  // register sequencer state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= IDLE;
      cnt_q   <= '0;
      addr_q  <= sram_host_pkg::ADDR_RESET;
      wdata_q <= sram_host_pkg::DATA_RESET;
      rdata_q <= sram_host_pkg::DATA_RESET;
      ready_q <= 1'b0;
      rsp_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      rsp_q   <= rsp_d;
    end
  end

  // ***********************************************************
  // handshake outputs
  // ***********************************************************
  // each output taken straight from its flop
  assign req_ready_out = ready_q;
  assign rsp_valid_out = rsp_q;
  assign rsp_rdata_out = rdata_q;

  // ***********************************************************
  // registered pin stage
  // ***********************************************************
  // every pin leaves through one flop, read data returns through two
  sram_pin_stage u_pins (
    .clk_in               (clk_in),
    .rst_in               (rst_in),
    .p                    (pins_bus),
    .data_pin_in          (data_pin_in),
    .addr_out             (addr_out),
    .primary_select_n_out (primary_select_n_out),
    .secondary_select_out (secondary_select_out),
    .write_strobe_n_out   (write_strobe_n_out),
    .output_drive_n_out   (output_drive_n_out),
    .data_pin_out         (data_pin_out),
    .data_pin_oe_n_out    (data_pin_oe_n_out)
  );
endmodule

// *** verification/sram_host_ctrl_properties.sv ***
/* Pin timing checker for sram_host_ctrl.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module sram_host_ctrl_properties (
  input logic        clk_in,
  input logic        rst_in,
  input logic        req_valid_in,
  input logic        req_write_in,
  input logic        req_ready_out,
  input logic        rsp_valid_out,
  input logic [20:0] addr_out,
  input logic        primary_select_n_out,
  input logic        secondary_select_out,
  input logic        write_strobe_n_out,
  input logic        output_drive_n_out,
  input logic [7:0]  data_pin_out,
  input logic        data_pin_oe_n_out
);
  logic sel;
  logic take;
  // combined select and request taken
  assign sel = !primary_select_n_out && secondary_select_out;
  assign take = req_valid_in && req_ready_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_pair; secondary_select_out == !primary_select_n_out; endproperty
  a_pair: assert property (p_pair) else $error("select pair split");
  property p_wr_sel; !write_strobe_n_out |-> sel; endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("strobe without select");
  property p_wr_len;
    $fell(write_strobe_n_out) |=> !write_strobe_n_out[*8] ##1 write_strobe_n_out;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("strobe low time");
  property p_wr_end;
    $rose(write_strobe_n_out) |-> sel && $stable(data_pin_out) && $stable(addr_out);
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("write end hold");
  property p_fight; !data_pin_oe_n_out |-> output_drive_n_out; endproperty
  a_fight: assert property (p_fight) else $error("data pins contended");
  property p_rd_wr; sel && !output_drive_n_out |-> write_strobe_n_out; endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("strobe low in read");
  property p_addr;
    sel && (!output_drive_n_out || $past(sel)) |-> $stable(addr_out);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved while selected");
  property p_rd_rsp; take && !req_write_in |-> ##14 rsp_valid_out ##1 !rsp_valid_out; endproperty
  a_rd_rsp: assert property (p_rd_rsp) else $error("read answer time");
  property p_wr_rsp; take && req_write_in |-> ##12 rsp_valid_out ##1 !rsp_valid_out; endproperty
  a_wr_rsp: assert property (p_wr_rsp) else $error("write answer time");
endmodule
bind sram_host_ctrl sram_host_ctrl_properties u_props (.clk_in, .rst_in, .req_valid_in,
  .req_write_in, .req_ready_out, .rsp_valid_out, .addr_out, .primary_select_n_out,
  .secondary_select_out, .write_strobe_n_out, .output_drive_n_out, .data_pin_out,
  .data_pin_oe_n_out);

// *** verification/sram_mem_model.sv ***
/* Behavioural byte memory on the host pins.
   Assumes the bench resolves the shared data lines. */
`timescale 1ns/1ps
module sram_mem_model #(parameter int ACC_NS = 45) (
  input  logic [20:0] addr_in,
  input  logic        sel1_n_in,
  input  logic        sel2_in,
  input  logic        wr_n_in,
  input  logic        oe_n_in,
  input  logic [7:0]  data_in,
  output logic [7:0]  data_out,
  output logic        drive_out
);
  logic [7:0] mem [logic [20:0]];
  logic       sel;
  logic       wr;
  logic       wr_was = 1'b0;
  // decode of selects, strobe and output drive
  assign sel = !sel1_n_in && sel2_in;
  assign wr = sel && !wr_n_in;
  assign drive_out = sel && wr_n_in && !oe_n_in;
  // store when the overlap ends, then read after the access time
  always @(addr_in or wr) begin
    if (!wr && wr_was) mem[addr_in] = data_in;
    wr_was = wr;
    data_out <= #(ACC_NS) mem.exists(addr_in) ? mem[addr_in] : ~addr_in[7:0];
  end
endmodule

// *** verification/async_sram_byte_interface_test.sv ***
/* Bench for sram_host_ctrl with a byte memory model.
   Assumes the memory model file is compiled first. */
`timescale 1ns/1ps
module async_sram_byte_interface_test;
  logic        clk_in = 0, rst_in = 1, req_valid_in = 0, req_write_in = 0;
  logic [20:0] req_addr_in = 0, addr_out, a;
  logic [7:0]  req_wdata_in = 0, rsp_rdata_out, data_pin_in, data_pin_out, mem_data, d;
  logic [7:0]  junk = 0;
  logic        req_ready_out, rsp_valid_out, primary_select_n_out, secondary_select_out;
  logic        write_strobe_n_out, output_drive_n_out, data_pin_oe_n_out, mem_drive;
  int          errors = 0, n_compared = 0, cycles = 0;
  logic [7:0]  ref_mem [int];
  int          q [$];
  sram_host_ctrl dut (.clk_in, .rst_in, .req_valid_in, .req_write_in, .req_addr_in,
    .req_wdata_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .data_pin_in, .addr_out,
    .primary_select_n_out, .secondary_select_out, .write_strobe_n_out, .output_drive_n_out,
    .data_pin_out, .data_pin_oe_n_out);
  sram_mem_model #(.ACC_NS(sram_host_pkg::T_AA_NS)) mem (.addr_in(addr_out),
    .sel1_n_in(primary_select_n_out), .sel2_in(secondary_select_out),
    .wr_n_in(write_strobe_n_out), .oe_n_in(output_drive_n_out), .data_in(data_pin_in),
    .data_out(mem_data), .drive_out(mem_drive));
  // released lines show a pattern that changes every cycle
  assign data_pin_in = !data_pin_oe_n_out ? data_pin_out : mem_drive ? mem_data : junk;
  initial forever #2.5 clk_in = ~clk_in;
  // cycle ceiling against hangs
  always @(posedge clk_in) begin
    junk <= junk + 8'h3B;
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one request, answer time and read data against the reference
  task automatic access(input logic wr, input logic [20:0] ad, input logic [7:0] dt);
    int n;
    int lat;
    n = 0;
    // take to answer: one setup edge, the wait itself, one closing edge
    lat = wr ? sram_host_pkg::WR_LOW_CYC + 2 : sram_host_pkg::RD_CYC + 2;
    while (req_ready_out !== 1'b1) @(posedge clk_in) #1;
    req_valid_in = 1;
    req_write_in = wr;
    req_addr_in = ad;
    req_wdata_in = dt;
    @(posedge clk_in) #1;
    req_valid_in = 0;
    while (rsp_valid_out !== 1'b1) begin
      @(posedge clk_in) #1;
      n++;
    end
    check("latency", 8'(n), 8'(lat));
    if (wr) ref_mem[ad] = dt;
    else check("rdata", rsp_rdata_out, ref_mem[ad]);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(60));
    repeat (2) @(posedge clk_in) #1;
    rst_in = 0;
    check("idle select", 8'(primary_select_n_out), 8'd1);
    // boundary addresses and an overwrite read back
    access(1, 21'h000000, 8'h5A);
    access(1, 21'h1FFFFF, 8'hC3);
    access(1, 21'h1FFFFF, 8'h3C);
    access(0, 21'h000000, 8'h00);
    access(0, 21'h1FFFFF, 8'h00);
    // random writes, then reads in reverse order
    for (int i = 0; i < 8; i++) begin
      a = 21'($urandom);
      d = 8'($urandom);
      q.push_back(a);
      access(1, a, d);
    end
    while (q.size() > 0) access(0, 21'(q.pop_back()), 8'h00);
    // reset in mid read, then contents still hold
    while (req_ready_out !== 1'b1) @(posedge clk_in) #1;
    req_valid_in = 1;
    @(posedge clk_in) #1;
    req_valid_in = 0;
    repeat (6) @(posedge clk_in) #1;
    rst_in = 1;
    repeat (2) @(posedge clk_in) #1;
    check("strobe in reset", 8'(write_strobe_n_out), 8'd1);
    check("ready in reset", 8'(req_ready_out), 8'd0);
    check("select in reset", 8'(primary_select_n_out), 8'd1);
    rst_in = 0;
    access(0, 21'h1FFFFF, 8'h00);
    end_of_test();
  end
endmodule
